// ===== hdl/tcs_regs.svh
// register offsets, field positions and reset values of the comparator block
`ifndef TCS_REGS_SVH
`define TCS_REGS_SVH

// byte offsets on the register bus
`define TCS_OFS_CTRL 8'h00
`define TCS_OFS_FLAG 8'h04
`define TCS_OFS_IEN 8'h08
`define TCS_OFS_IRQC 8'h0C

// comparator_control_reg fields
`define TCS_CTRL_RES_HI 7
`define TCS_CTRL_RES_LO 5
`define TCS_CTRL_EN_HI 2
`define TCS_CTRL_EN_LO 0

// peripheral_flag_reg / peripheral_enable_reg fields
`define TCS_FLAG_HI 3
`define TCS_FLAG_LO 1

// irq_control_reg fields
`define TCS_IRQC_GIE 7
`define TCS_IRQC_PERIPHERAL_IRQ_ENABLE 6

// reset values
`define TCS_RST_EN 3'h0
`define TCS_RST_RES 3'h0
`define TCS_RST_FLAG 3'h0
`define TCS_RST_IE 3'h0

// bus answers
`define TCS_RESP_OKAY 2'h0
`define TCS_RESP_SLVERR 2'h2

`endif

// ===== hdl/tcs_pkg.sv
// types shared by the triple comparator status block
package tcs_pkg;

  typedef logic [2:0] tcs_tri_type;

  typedef struct packed {
    tcs_tri_type sync1;
    tcs_tri_type sync2;
    tcs_tri_type sync3;
    tcs_tri_type stable;
    tcs_tri_type enable;
    tcs_tri_type latched;
    tcs_tri_type flag;
    tcs_tri_type irq_en;
    logic periph_en;
    logic global_en;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } tcs_state_type;

endpackage : tcs_pkg

// ===== hdl/tcs_top.sv
// comparator control, change detection and interrupt gating behind AXI4-Lite
//
// Overview of operation
// - results readable only through control register
// - result high when input exceeds reference
// - results at bits 7:5, read-only, reset zero
// - enables at bits 2:0, read-write, reset zero
// - bits 4:3 read zero, writes ignored
// - result may be invalid while settling
// - flag set while result differs from latched
// - flags at bits 3:1, cleared by writing zero
// - writing one sets a flag
// - request needs comparator, peripheral, global enables
// - flag sets even when enables clear
// - access coinciding with change still sets flag
// - any control access relatches results
// - mismatch keeps setting flag over clears
// - enabled comparator keeps working in sleep
// - enabled comparator interrupt wakes from sleep
// - wake leaves control register unchanged
// - reset clears control register and enables
`include "tcs_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module tcs_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address channel
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // write data channel
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address channel
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // read data channel
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // analog side
  input wire logic [2:0] cmp_raw,
  output logic [2:0] cmp_enable_bits,
  // core side
  input wire logic sleep_mode,
  output logic irq_req,
  output logic wake_req
);

  tcs_pkg::tcs_state_type st_r;
  tcs_pkg::tcs_state_type st_nxt;

  logic wr_take;
  logic rd_take;
  logic [5:0] wr_word;
  logic [5:0] rd_word;
  logic wr_lane0;
  logic ctrl_access;
  tcs_pkg::tcs_tri_type cmp_result_bits;
  tcs_pkg::tcs_tri_type mismatch;
  tcs_pkg::tcs_tri_type pending;

  //////////////////////////////////////////////////////////////////////////////
  // bus handshake

  // write taken only with address and data together; the master holds both
  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !st_r.bvalid;
  assign s_axi_wready = s_axi_awready;
  assign s_axi_arready = !st_r.rvalid;
  assign wr_take = s_axi_awready;
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign wr_word = s_axi_awaddr[7:2];
  assign rd_word = s_axi_araddr[7:2];
  assign wr_lane0 = s_axi_wstrb[0];

  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rdata = st_r.rdata;

  //////////////////////////////////////////////////////////////////////////////
  // comparator view

  assign cmp_result_bits = st_r.stable & st_r.enable;
  assign mismatch = cmp_result_bits ^ st_r.latched;
  assign ctrl_access = (wr_take && wr_word == 6'(`TCS_OFS_CTRL >> 2))
                    || (rd_take && rd_word == 6'(`TCS_OFS_CTRL >> 2));
  assign pending = st_r.flag & st_r.irq_en;
  assign cmp_enable_bits = st_r.enable;
  assign irq_req = (|pending) && st_r.periph_en && st_r.global_en;
  // wake needs only the per-comparator enable
  assign wake_req = sleep_mode && (|pending);

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = cmp_raw;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.sync3 = st_r.sync2;
    // result moves only once two stages agree, filtering settle glitches
    for (int i = 0; i < 3; i++) begin
      if (st_r.sync2[i] == st_r.sync3[i]) begin
        st_nxt.stable[i] = st_r.sync3[i];
      end
    end
    // latch and compare in one cycle, so a coinciding change still flags
    if (ctrl_access) begin
      st_nxt.latched = cmp_result_bits;
    end

    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end

    if (wr_take) begin
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = `TCS_RESP_OKAY;
      unique case (wr_word)
        6'(`TCS_OFS_CTRL >> 2): begin
          if (wr_lane0) begin
            st_nxt.enable = s_axi_wdata[`TCS_CTRL_EN_HI:`TCS_CTRL_EN_LO];
          end
        end
        6'(`TCS_OFS_FLAG >> 2): begin
          if (wr_lane0) begin
            st_nxt.flag = s_axi_wdata[`TCS_FLAG_HI:`TCS_FLAG_LO];
          end
        end
        6'(`TCS_OFS_IEN >> 2): begin
          if (wr_lane0) begin
            st_nxt.irq_en = s_axi_wdata[`TCS_FLAG_HI:`TCS_FLAG_LO];
          end
        end
        6'(`TCS_OFS_IRQC >> 2): begin
          if (wr_lane0) begin
            st_nxt.global_en = s_axi_wdata[`TCS_IRQC_GIE];
            st_nxt.periph_en = s_axi_wdata[`TCS_IRQC_PERIPHERAL_IRQ_ENABLE];
          end
        end
        default: begin
          st_nxt.bresp = `TCS_RESP_SLVERR;
        end
      endcase
    end

    // hardware set wins over a software clear, regardless of enables
    st_nxt.flag = st_nxt.flag | mismatch;

    if (rd_take) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = `TCS_RESP_OKAY;
      st_nxt.rdata = 32'h0000_0000;
      unique case (rd_word)
        6'(`TCS_OFS_CTRL >> 2): begin
          st_nxt.rdata[`TCS_CTRL_RES_HI:`TCS_CTRL_RES_LO] = cmp_result_bits;
          st_nxt.rdata[`TCS_CTRL_EN_HI:`TCS_CTRL_EN_LO] = st_r.enable;
        end
        6'(`TCS_OFS_FLAG >> 2): begin
          st_nxt.rdata[`TCS_FLAG_HI:`TCS_FLAG_LO] = st_r.flag;
        end
        6'(`TCS_OFS_IEN >> 2): begin
          st_nxt.rdata[`TCS_FLAG_HI:`TCS_FLAG_LO] = st_r.irq_en;
        end
        6'(`TCS_OFS_IRQC >> 2): begin
          st_nxt.rdata[`TCS_IRQC_GIE] = st_r.global_en;
          st_nxt.rdata[`TCS_IRQC_PERIPHERAL_IRQ_ENABLE] = st_r.periph_en;
        end
        default: begin
          st_nxt.rresp = `TCS_RESP_SLVERR;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register

  // sleep never touches state, so detection runs and control survives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.enable <= `TCS_RST_EN;
      st_r.stable <= `TCS_RST_RES;
      st_r.latched <= `TCS_RST_RES;
      st_r.flag <= `TCS_RST_FLAG;
      st_r.irq_en <= `TCS_RST_IE;
    end else begin
      st_r <= st_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  flag_on_mismatch_a: assert property (|mismatch |=> (st_r.flag & $past(mismatch)) == $past(mismatch))
    else $error("change flag not set on mismatch");

  set_beats_clear_a: assert property (
    (wr_take && wr_word == 6'h01 && |mismatch) |=> |st_r.flag)
    else $error("software clear beat a live mismatch");

  access_relatch_a: assert property (ctrl_access |=> st_r.latched == $past(cmp_result_bits))
    else $error("control access did not relatch results");

  enable_write_a: assert property (
    (wr_take && wr_word == 6'h00 && wr_lane0) |=> cmp_enable_bits == $past(s_axi_wdata[2:0]))
    else $error("enable bits did not take the write");

  gap_reads_zero_a: assert property (
    (rd_take && rd_word == 6'h00) |=> s_axi_rdata[4:3] == 2'h0 && s_axi_rdata[31:8] == 24'h0)
    else $error("unimplemented control bits read nonzero");

  soft_set_a: assert property (
    (wr_take && wr_word == 6'h01 && wr_lane0 && s_axi_wdata[1]) |=> st_r.flag[0])
    else $error("software write of one did not set the flag");

  irq_gate_a: assert property (irq_req |-> st_r.global_en && st_r.periph_en && |pending)
    else $error("interrupt raised without all enables");

  flag_masked_a: assert property ((|mismatch && !st_r.global_en) |=> |st_r.flag)
    else $error("flag not set while interrupts masked");

  sync_agree_a: assert property (
    st_r.stable != $past(st_r.stable) |-> $past(st_r.sync2) == $past(st_r.sync3))
    else $error("result moved before synchroniser agreed");

  sleep_wake_a: assert property ((sleep_mode && |pending) |-> wake_req ##0 $stable(st_r.enable))
    else $error("enabled interrupt did not wake from sleep");

  reset_clear_a: assert property (@(posedge aclk) disable iff (1'b0)
    !aresetn |=> cmp_enable_bits == 3'h0 && !s_axi_bvalid && !s_axi_rvalid)
    else $error("reset left comparators enabled");

  bresp_hold_a: assert property ((s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before ready");

  rdata_hold_a: assert property ((s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before ready");

  flag_raised_c: cover property (st_r.flag == 3'h0 ##1 st_r.flag != 3'h0);
  irq_seen_c: cover property (irq_req);
  wake_seen_c: cover property (wake_req);
  bad_addr_c: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);

endmodule : tcs_top

`default_nettype wire

// ===== verif/tcs_top_tb.sv
// self-checking testbench of the triple comparator status block
`include "tcs_regs.svh"
`timescale 1ns/1ns
`default_nettype none

`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end end

module tcs_top_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, irq_req, wake_req;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [2:0] cmp_raw = 3'h0, cmp_en;
  logic sleep_mode = 1'b0;
  int errors = 0;
  int n_tests = 0;

  tcs_top i_tcs_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cmp_raw(cmp_raw),
    .cmp_enable_bits(cmp_en), .sleep_mode(sleep_mode), .irq_req(irq_req),
    .wake_req(wake_req));

  initial begin
    forever #20 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    if (errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    @(posedge aclk);
    while (awready !== 1'b1) @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    @(posedge aclk);
    while (bvalid !== 1'b1) @(posedge aclk);
    `CHK(bresp, er)
    bready <= 1'b0;
    @(posedge aclk);
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge aclk);
    while (arready !== 1'b1) @(posedge aclk);
    arvalid <= 1'b0;
    @(posedge aclk);
    while (rvalid !== 1'b1) @(posedge aclk);
    `CHK(rdata, ed)
    `CHK(rresp, er)
    rready <= 1'b0;
    @(posedge aclk);
  endtask : bus_rd

  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////////
  // reset values, enable field and unimplemented bits
  task automatic t_regs;
    bus_rd(`TCS_OFS_CTRL, 32'h0, `TCS_RESP_OKAY);
    bus_rd(`TCS_OFS_FLAG, 32'h0, `TCS_RESP_OKAY);
    `CHK(cmp_en, 3'h0)
    bus_wr(`TCS_OFS_CTRL, 32'h0000_00FF, `TCS_RESP_OKAY);
    bus_rd(`TCS_OFS_CTRL, 32'h0000_0007, `TCS_RESP_OKAY);
    `CHK(cmp_en, 3'h7)
  endtask : t_regs

  // change detection, sticky flag while mismatched, relatch on access
  task automatic t_change;
    cmp_raw <= 3'h5;
    repeat (8) @(posedge aclk);
    bus_rd(`TCS_OFS_FLAG, 32'h0000_000A, `TCS_RESP_OKAY);
    `CHK(irq_req, 1'b0)
    bus_wr(`TCS_OFS_FLAG, 32'h0, `TCS_RESP_OKAY);
    bus_rd(`TCS_OFS_FLAG, 32'h0000_000A, `TCS_RESP_OKAY);
    // reading control relatches the results and ends the mismatch
    bus_rd(`TCS_OFS_CTRL, 32'h0000_00A7, `TCS_RESP_OKAY);
    bus_wr(`TCS_OFS_FLAG, 32'h0, `TCS_RESP_OKAY);
    bus_rd(`TCS_OFS_FLAG, 32'h0, `TCS_RESP_OKAY);
  endtask : t_change

  // software-set flag and three-level interrupt gating
  task automatic t_irq;
    bus_wr(`TCS_OFS_FLAG, 32'h0000_0004, `TCS_RESP_OKAY);
    bus_rd(`TCS_OFS_FLAG, 32'h0000_0004, `TCS_RESP_OKAY);
    bus_wr(`TCS_OFS_IEN, 32'h0000_000E, `TCS_RESP_OKAY);
    bus_wr(`TCS_OFS_IRQC, 32'h0000_0040, `TCS_RESP_OKAY);
    `CHK(irq_req, 1'b0)
    bus_wr(`TCS_OFS_IRQC, 32'h0000_00C0, `TCS_RESP_OKAY);
    `CHK(irq_req, 1'b1)
    bus_wr(`TCS_OFS_FLAG, 32'h0, `TCS_RESP_OKAY);
    `CHK(irq_req, 1'b0)
    bus_wr(`TCS_OFS_IRQC, 32'h0, `TCS_RESP_OKAY);
  endtask : t_irq

  // detection keeps running in sleep and wakes the core
  task automatic t_sleep;
    sleep_mode <= 1'b1;
    cmp_raw <= 3'h7;
    repeat (8) @(posedge aclk);
    `CHK(wake_req, 1'b1)
    bus_rd(`TCS_OFS_FLAG, 32'h0000_0004, `TCS_RESP_OKAY);
    sleep_mode <= 1'b0;
    @(posedge aclk);
    bus_rd(`TCS_OFS_CTRL, 32'h0000_00E7, `TCS_RESP_OKAY);
  endtask : t_sleep

  // unmapped address refused on both channels, then mid-run reset
  task automatic t_err_rst;
    bus_rd(8'h10, 32'h0, `TCS_RESP_SLVERR);
    bus_wr(8'h10, 32'hFFFF_FFFF, `TCS_RESP_SLVERR);
    bus_rd(`TCS_OFS_CTRL, 32'h0000_00E7, `TCS_RESP_OKAY);
    bus_wr(`TCS_OFS_CTRL, 32'h0, `TCS_RESP_OKAY);
    `CHK(cmp_en, 3'h0)
    do_reset();
    `CHK(cmp_en, 3'h0)
    bus_rd(`TCS_OFS_CTRL, 32'h0, `TCS_RESP_OKAY);
  endtask : t_err_rst

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    t_regs();
    t_change();
    t_irq();
    t_sleep();
    t_err_rst();
    test_done();
  end

  // hang guard: the whole sequence needs well under 1000 cycles
  initial begin
    #(40 * 5000);
    errors++;
    test_done();
  end
endmodule : tcs_top_tb

`default_nettype wire
